// ==== verilog/cpsc_pkg.sv ====
package cpsc_pkg;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          CYC_PER_MS      = CLK_HZ / 1000;
    localparam logic [15:0] CMD_PERSIST     = 16'h3615;
    localparam logic [15:0] CMD_SERIAL      = 16'h3682;
    localparam logic [15:0] CMD_SELFTEST    = 16'h3639;
    localparam int          PERSIST_MS      = 800;
    localparam int          SERIAL_MS       = 1;
    localparam int          SELFTEST_MS     = 10000;
    localparam int          PERSIST_CYC     = PERSIST_MS * CYC_PER_MS;
    localparam int          SERIAL_CYC      = SERIAL_MS * CYC_PER_MS;
    localparam int          SELFTEST_CYC    = SELFTEST_MS * CYC_PER_MS;
    localparam int          WEAR_LIMIT      = 2000;
    localparam int          SERIAL_BYTES    = 9;
    localparam int          SELFTEST_BYTES  = 3;
    localparam logic [7:0]  CRC_POLY        = 8'h31;
    localparam logic [7:0]  CRC_INIT        = 8'hFF;
    localparam int          CFG_W           = 32;
    localparam logic [CFG_W-1:0] CFG_RST    = 32'h0000_0000;
    localparam int          CNT_W           = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 32'h0000_0000;
    localparam logic [3:0]  IDX_ZERO        = 4'h0;
    localparam logic [11:0] WEAR_ZERO       = 12'h000;
    typedef enum logic [2:0] {
        CPSC_IDLE    = 3'b000,
        CPSC_PERSIST = 3'b001,
        CPSC_SERIAL  = 3'b010,
        CPSC_SELFT   = 3'b011,
        CPSC_RESP    = 3'b100
    } cpsc_state_t;
endpackage

// ==== verilog/cpsc_nvm.sv ====
`timescale 1ns/1ns
module cpsc_nvm
    import cpsc_pkg::*;
(
    input  wire logic             i_clk_sys,  // system clock
    input  wire logic             i_rst,      // async reset, high
    input  wire logic             i_we,       // store strobe
    input  wire logic [CFG_W-1:0] i_wdata,    // config to store
    output logic      [CFG_W-1:0] o_rdata     // stored config, registered
);
    logic [CFG_W-1:0] mem_r;
    logic [CFG_W-1:0] mem_nxt;
    logic [CFG_W-1:0] rd_r;

    always_comb
    begin
        mem_nxt = i_we ? i_wdata : mem_r;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_r <= CFG_RST;
            rd_r  <= CFG_RST;
        end
        else
        begin
            mem_r <= mem_nxt;
            rd_r  <= mem_r;
        end
    end

    assign o_rdata = rd_r;
endmodule

// ==== verilog/cpsc_core.sv ====
`timescale 1ns/1ns
module cpsc_core
    import cpsc_pkg::*;
#(
    parameter int          P_PERSIST_CYC  = PERSIST_CYC,
    parameter int          P_SELFTEST_CYC = SELFTEST_CYC,
    parameter logic [47:0] P_SERIAL       = 48'h0123_4567_89AB  // arbitrary value
)
(
    input  wire logic             i_clk_sys,      // system clock
    input  wire logic             i_rst,          // async reset, high
    input  wire logic             i_cmd_valid,    // command strobe
    input  wire logic [15:0]      i_cmd,          // command code
    input  wire logic             i_cfg_we,       // volatile config write
    input  wire logic [CFG_W-1:0] i_cfg_wdata,    // volatile config data
    input  wire logic             i_cal_event,    // calibration update event
    input  wire logic [15:0]      i_cal_data,     // calibration history word
    input  wire logic             i_st_fault,     // function fault seen
    input  wire logic             i_supply_bad,   // supply fault seen
    input  wire logic             i_rd_req,       // host reads next byte
    output logic                  o_busy,         // command executing
    output logic                  o_rd_valid,     // response byte valid
    output logic [7:0]            o_rd_data,      // response byte
    output logic                  o_rd_last,      // final response byte
    output logic [CFG_W-1:0]      o_cfg,          // volatile config
    output logic [CFG_W-1:0]      o_nvm_cfg,      // stored config
    output logic [15:0]           o_cal_hist,     // saved calibration history
    output logic                  o_wear_out,     // store endurance limit reached
    output logic                  o_cmd_err       // unknown command seen
);
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [7:0] pick(input logic [47:0] v, input logic [3:0] k);
        logic [15:0] w;
        w = v[47 - 16 * (k / 3) -: 16];
        case (k % 3)
            0:       return w[15:8];
            1:       return w[7:0];
            default: return crc8(w);
        endcase
    endfunction

    cpsc_state_t      st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0]       idx_r, idx_nxt;
    logic [3:0]       nbytes_r, nbytes_nxt;
    logic [47:0]      resp_r, resp_nxt;
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic [15:0]      cal_r, cal_nxt;
    logic [11:0]      wear_r, wear_nxt;
    logic             busy_r, busy_nxt;
    logic             val_r, val_nxt;
    logic [7:0]       dat_r, dat_nxt;
    logic             last_r, last_nxt;
    logic             err_r, err_nxt;
    logic             wear_out_r, wear_out_nxt;
    logic             store_we;

    cpsc_nvm u_nvm (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_we      (store_we),
        .i_wdata   (cfg_r),
        .o_rdata   (o_nvm_cfg)
    );

    always_comb
    begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        idx_nxt    = idx_r;
        nbytes_nxt = nbytes_r;
        resp_nxt   = resp_r;
        busy_nxt   = busy_r;
        val_nxt    = 1'b0;
        dat_nxt    = dat_r;
        last_nxt   = 1'b0;
        err_nxt    = 1'b0;
        store_we   = 1'b0;
        wear_nxt   = wear_r;
        cfg_nxt    = i_cfg_we ? i_cfg_wdata : cfg_r;
        cal_nxt    = i_cal_event ? i_cal_data : cal_r;
        case (st_r)
            CPSC_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    cnt_nxt  = CNT_ZERO;
                    busy_nxt = 1'b1;
                    case (i_cmd)
                        CMD_PERSIST:  st_nxt = CPSC_PERSIST;
                        CMD_SERIAL:
                        begin
                            st_nxt     = CPSC_SERIAL;
                            resp_nxt   = P_SERIAL;
                            nbytes_nxt = 4'(SERIAL_BYTES);
                        end
                        CMD_SELFTEST:
                        begin
                            st_nxt     = CPSC_SELFT;
                            nbytes_nxt = 4'(SELFTEST_BYTES);
                        end
                        default:
                        begin
                            busy_nxt = 1'b0;
                            err_nxt  = 1'b1;
                        end
                    endcase
                end
            end
            CPSC_PERSIST:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(P_PERSIST_CYC - 1))
                begin
                    store_we = 1'b1;
                    if (wear_r != 12'(WEAR_LIMIT))
                    begin
                        wear_nxt = wear_r + 1'b1;
                    end
                    busy_nxt = 1'b0;
                    st_nxt   = CPSC_IDLE;
                end
            end
            CPSC_SERIAL, CPSC_SELFT:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (st_r == CPSC_SELFT && (i_st_fault || i_supply_bad))
                begin
                    resp_nxt[47] = 1'b1;
                end
                if (cnt_r == CNT_W'((st_r == CPSC_SERIAL ? SERIAL_CYC : P_SELFTEST_CYC) - 1))
                begin
                    busy_nxt = 1'b0;
                    idx_nxt  = IDX_ZERO;
                    st_nxt   = CPSC_RESP;
                end
            end
            CPSC_RESP:
            begin
                if (i_cmd_valid)
                begin
                    st_nxt = CPSC_IDLE;
                end
                else if (i_rd_req && !val_r)
                begin
                    val_nxt  = 1'b1;
                    dat_nxt  = pick(resp_r, idx_r);
                    last_nxt = (idx_r == nbytes_r - 1'b1);
                    idx_nxt  = idx_r + 1'b1;
                    if (idx_r == nbytes_r - 1'b1)
                    begin
                        st_nxt = CPSC_IDLE;
                    end
                end
            end
            default: st_nxt = CPSC_IDLE;
        endcase
        if (st_r == CPSC_IDLE && i_cmd_valid && i_cmd == CMD_SELFTEST)
        begin
            resp_nxt = 48'h0;
        end
        // endurance flag registered so the output comes from a flop
        wear_out_nxt = (wear_nxt == 12'(WEAR_LIMIT));
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r     <= CPSC_IDLE;
            cnt_r    <= CNT_ZERO;
            idx_r    <= IDX_ZERO;
            nbytes_r <= IDX_ZERO;
            resp_r   <= 48'h0;
            cfg_r    <= CFG_RST;
            cal_r    <= 16'h0000;
            wear_r   <= WEAR_ZERO;
            busy_r   <= 1'b0;
            val_r    <= 1'b0;
            dat_r    <= 8'h00;
            last_r   <= 1'b0;
            err_r    <= 1'b0;
            wear_out_r <= 1'b0;
        end
        else
        begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            idx_r    <= idx_nxt;
            nbytes_r <= nbytes_nxt;
            resp_r   <= resp_nxt;
            cfg_r    <= cfg_nxt;
            cal_r    <= cal_nxt;
            wear_r   <= wear_nxt;
            busy_r   <= busy_nxt;
            val_r    <= val_nxt;
            dat_r    <= dat_nxt;
            last_r   <= last_nxt;
            err_r    <= err_nxt;
            wear_out_r <= wear_out_nxt;
        end
    end

    assign o_busy     = busy_r;
    assign o_rd_valid = val_r;
    assign o_rd_data  = dat_r;
    assign o_rd_last  = last_r;
    assign o_cfg      = cfg_r;
    assign o_cal_hist = cal_r;
    assign o_wear_out = wear_out_r;
    assign o_cmd_err  = err_r;
endmodule

// ==== verification/cpsc_core_sva.sv ====
`timescale 1ns/1ns
module cpsc_sva
    import cpsc_pkg::*;
#(
    parameter int P_PERSIST_CYC  = 20,
    parameter int P_SELFTEST_CYC = 30
)
(
    input  wire logic             i_clk_sys,   // clock
    input  wire logic             i_rst,       // reset
    input  wire logic             i_cmd_valid, // strobe
    input  wire logic [15:0]      i_cmd,       // code
    input  wire logic             i_cfg_we,    // cfg write
    input  wire logic [CFG_W-1:0] i_cfg_wdata, // cfg data
    input  wire logic             i_rd_req,    // byte request
    input  wire logic             o_busy,      // busy
    input  wire logic             o_rd_valid,  // byte valid
    input  wire logic             o_rd_last,   // last byte
    input  wire logic [CFG_W-1:0] o_cfg,       // config
    input  wire logic [CFG_W-1:0] o_nvm_cfg    // stored config
);
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    logic        bq_r;
    logic        pend_r;
    logic        pend_nxt;
    logic [3:0]  nb_r;
    logic [3:0]  nb_nxt;
    logic        go;
    assign go = i_cmd_valid && !o_busy && !pend_r;
    // track accepted command, pending answer, bytes sent
    always_comb
    begin
        cmd_nxt  = go ? i_cmd : cmd_r;
        nb_nxt   = go ? 4'h0 : nb_r + {3'h0, o_rd_valid};
        pend_nxt = pend_r;
        if (bq_r && !o_busy && cmd_r != CMD_PERSIST)
            pend_nxt = 1'b1;
        if ((o_rd_valid && o_rd_last) || (i_cmd_valid && !o_busy))
            pend_nxt = 1'b0;
    end
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            cmd_r  <= 16'h0000;
            bq_r   <= 1'b0;
            pend_r <= 1'b0;
            nb_r   <= 4'h0;
        end
        else
        begin
            cmd_r  <= cmd_nxt;
            bq_r   <= o_busy;
            pend_r <= pend_nxt;
            nb_r   <= nb_nxt;
        end
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    property p_persist;
        go && i_cmd == CMD_PERSIST |-> ##P_PERSIST_CYC o_busy ##1 !o_busy;
    endproperty
    a_persist: assert property (p_persist) else $error("persist time");
    property p_store;
        bq_r && !o_busy && cmd_r == CMD_PERSIST |-> ##[0:3] o_nvm_cfg == o_cfg;
    endproperty
    a_store: assert property (p_store) else $error("store missing");
    property p_cfg;
        i_cfg_we |=> o_cfg == $past(i_cfg_wdata);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg write");
    property p_serial;
        go && i_cmd == CMD_SERIAL |=> o_busy [*8];
    endproperty
    a_serial: assert property (p_serial) else $error("serial busy");
    property p_selft;
        go && i_cmd == CMD_SELFTEST |-> ##P_SELFTEST_CYC o_busy ##1 !o_busy;
    endproperty
    a_selft: assert property (p_selft) else $error("self-test time");
    property p_ans;
        pend_r && i_rd_req && !o_rd_valid && !i_cmd_valid |=> o_rd_valid;
    endproperty
    a_ans: assert property (p_ans) else $error("no byte");
    property p_cnt;
        o_rd_valid |-> o_rd_last == (nb_r == (cmd_r == CMD_SERIAL ? 4'h8 : 4'h2));
    endproperty
    a_cnt: assert property (p_cnt) else $error("byte count");
    property p_gap;
        o_rd_valid |=> !o_rd_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("byte pulse");
endmodule
bind cpsc_core cpsc_sva #(.P_PERSIST_CYC(P_PERSIST_CYC), .P_SELFTEST_CYC(P_SELFTEST_CYC))
    sva_u (.i_clk_sys, .i_rst, .i_cmd_valid, .i_cmd, .i_cfg_we, .i_cfg_wdata, .i_rd_req,
    .o_busy, .o_rd_valid, .o_rd_last, .o_cfg, .o_nvm_cfg);

// ==== verification/cpsc_host.sv ====
`timescale 1ns/1ns
module cpsc_host
(
    input  wire logic        i_clk_sys,   // clock
    input  wire logic        i_busy,      // device busy
    input  wire logic        i_rd_valid,  // byte valid
    input  wire logic [7:0]  i_rd_data,   // byte
    output logic             o_cmd_valid, // strobe
    output logic [15:0]      o_cmd,       // code
    output logic             o_rd_req     // byte request
);
    logic [7:0] rx [9];
    int         blen;
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd = 16'h0000;
        o_rd_req = 1'b0;
    end
    // one command, wait out its run time, then fetch nb bytes
    task automatic exec(input logic [15:0] c, input int nb);
        int t;
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b1;
        o_cmd <= c;
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b0;
        o_cmd <= ~c;
        blen = 0;
        @(negedge i_clk_sys);
        while (i_busy === 1'b1 && blen < 60000)
        begin
            blen++;
            @(negedge i_clk_sys);
        end
        for (int i = 0; i < nb; i++)
        begin
            @(posedge i_clk_sys);
            o_rd_req <= 1'b1;
            t = 0;
            do
            begin
                @(negedge i_clk_sys);
                t++;
            end while (i_rd_valid !== 1'b1 && t < 4);
            rx[i] = i_rd_data;
            @(posedge i_clk_sys);
            o_rd_req <= 1'b0;
        end
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
    import cpsc_pkg::*;
    localparam logic [47:0] SER = 48'h5A3C_0F1E_2D4B; // arbitrary value
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_cfg_we = 1'b0, i_cal_event = 1'b0, i_st_fault = 1'b0, i_supply_bad = 1'b0;
    logic        i_cmd_valid, i_rd_req, o_busy, o_rd_valid, o_rd_last, o_wear_out, o_cmd_err;
    logic [15:0] i_cmd, o_cal_hist, i_cal_data = 16'h0000;
    logic [31:0] o_cfg, o_nvm_cfg, stored = 32'h0, i_cfg_wdata = 32'h0;
    logic [7:0]  o_rd_data;
    int          n_fail = 0, checks = 0, cyc = 0, np = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    cpsc_core #(.P_PERSIST_CYC(20), .P_SELFTEST_CYC(30), .P_SERIAL(SER)) dut_u (
        .i_clk_sys, .i_rst, .i_cmd_valid, .i_cmd, .i_cfg_we, .i_cfg_wdata,
        .i_cal_event, .i_cal_data, .i_st_fault, .i_supply_bad, .i_rd_req,
        .o_busy, .o_rd_valid, .o_rd_data, .o_rd_last, .o_cfg, .o_nvm_cfg,
        .o_cal_hist, .o_wear_out, .o_cmd_err);
    cpsc_host host_u (.i_clk_sys, .i_busy(o_busy), .i_rd_valid(o_rd_valid),
        .i_rd_data(o_rd_data), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_rd_req(i_rd_req));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        return c;
    endfunction
    task automatic word(input int i, input logic [15:0] w);
        chk({host_u.rx[i], host_u.rx[i+1]}, {48'h0, w});
        chk(host_u.rx[i+2], crc8(w));
    endtask
    // new random config and calibration word, checked once written
    task automatic stim(output logic [31:0] d);
        logic [15:0] c;
        d = $urandom;
        c = $urandom;
        @(posedge i_clk_sys);
        i_cfg_we <= 1'b1;
        i_cfg_wdata <= d;
        i_cal_event <= 1'b1;
        i_cal_data <= c;
        @(posedge i_clk_sys);
        i_cfg_we <= 1'b0;
        i_cal_event <= 1'b0;
        @(negedge i_clk_sys);
        chk(o_cfg, d);
        chk(o_cal_hist, c);
    endtask
    task automatic persist();
        logic [31:0] d;
        stim(d);
        chk(o_nvm_cfg, stored);
        host_u.exec(CMD_PERSIST, 0);
        chk(host_u.blen, 20);
        stored = d;
        np++;
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 105000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        logic [47:0] sn;
        void'($urandom(30688));
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk({o_busy, o_rd_valid, o_wear_out, o_cmd_err, o_nvm_cfg}, 0);
        persist();
        host_u.exec(CMD_SERIAL, 9);
        chk(host_u.blen, SERIAL_CYC);
        for (int k = 0; k < 3; k++)
            word(3 * k, SER[47 - 16 * k -: 16]);
        sn = ({32'h0, host_u.rx[0], host_u.rx[1]} << 32) | ({32'h0, host_u.rx[3],
            host_u.rx[4]} << 16) | {32'h0, host_u.rx[6], host_u.rx[7]};
        chk(sn, SER);
        $display("serial test done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk_sys);
            i_st_fault <= k[0];
            i_supply_bad <= k[1];
            host_u.exec(CMD_SELFTEST, 3);
            chk(host_u.blen, 30);
            word(0, (k == 0) ? 16'h0000 : 16'h8000);
            if (k == 0)
                chk(host_u.rx[2], 8'h81);
        end
        $display("self-test done");
        host_u.exec({4'hA, 12'($urandom)}, 0);
        chk(o_cmd_err, 1'b1);
        chk(host_u.blen, 0);
        @(negedge i_clk_sys);
        chk(o_cmd_err, 1'b0);
        host_u.exec(CMD_SELFTEST, 0);
        chk(host_u.blen, 30);
        host_u.exec(CMD_PERSIST, 0);
        chk(host_u.blen, 0);
        chk(o_nvm_cfg, stored);
        $display("command test done");
        while (np < 1999)
            persist();
        chk(o_wear_out, 0);
        persist();
        repeat (3) @(negedge i_clk_sys);
        chk(o_wear_out, 1);
        chk(o_nvm_cfg, stored);
        $display("store test done");
        end_sim();
    end
endmodule
